// ---- rtl/wit_pkg.sv ----
// Purpose: shared constants and types for the wave instrument telemetry link
// Assumes: bus clock 806.4 kHz on its own clock port, system clock 25 MHz
// Notes: rate divisors count bus clock cycles per high-rate bit
//
// Functional notes
// R1: halve bus clock; shift supervisory and reply bits
// R2: internal and high-rate timing derived from bus clock
// R3: host pulses timing line 620 ns every 66.7 ms
// R4: align timing using pulse plus broadcast time word
// R5: host sends supervisory data RZ at 403.2 kb/s
// R6: reply telemetry sent RZ at 403.2 kb/s
// R7: high nibble every other word, three rates
// R8: low nibble carries alternate words, same rate
// R9: host pairs high and low nibble into byte
// R10: instrument drives its own high-rate bit clock
// R11: word sync once every four bit clocks
// R12: countdowns are harmonics of 2.4 kHz power; the /128 rate gives 6.3 kHz, which is not a harmonic
// R13: RZ one high first quarter, zero low
package wit_pkg;
    typedef enum logic [1:0] {
        WIT_RATE_403K = 2'b00,
        WIT_RATE_50K = 2'b01,
        WIT_RATE_6K = 2'b10
    } wit_rate_t;

    typedef enum logic {
        WIT_TX_IDLE = 1'b0,
        WIT_TX_SEND = 1'b1
    } wit_tx_t;

    localparam int WIT_POWER_HZ = 2400;
    localparam int WIT_BUS_CLOCK_HZ = 806400;
    localparam int WIT_SYS_CLOCK_HZ = 25000000;
    // bus cycles per high-rate bit: 806.4k/2, /16, /128
    localparam logic [7:0] WIT_DIV_403K = 8'h02;
    localparam logic [7:0] WIT_DIV_50K = 8'h10;
    localparam logic [7:0] WIT_DIV_6K = 8'h80;
    localparam logic [4:0] WIT_TIME_LAST = 5'h1F;
    localparam logic [1:0] WIT_NIBBLE_LAST = 2'h3;
    localparam logic [3:0] WIT_REPLY_BITS = 4'h8;
    localparam logic [1:0] WIT_BUF_DEPTH = 2'h2;

    function automatic logic [7:0] wit_rate_div(input logic [1:0] rate);
        case (rate)
            WIT_RATE_403K: wit_rate_div = WIT_DIV_403K;
            WIT_RATE_50K: wit_rate_div = WIT_DIV_50K;
            WIT_RATE_6K: wit_rate_div = WIT_DIV_6K;
            default: wit_rate_div = WIT_DIV_403K;
        endcase
    endfunction : wit_rate_div
endpackage : wit_pkg

// ---- rtl/wit_pair_buffer.sv ----
// Purpose: two-entry byte buffer with valid and ready on both sides
// Assumes: single clock domain
// Notes: in_ready is registered
module wit_pair_buffer
    import wit_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    logic [7:0] slot0;
    logic [7:0] slot1;
    logic [1:0] count;
    logic [7:0] next_slot0;
    logic [7:0] next_slot1;
    logic [1:0] next_count;
    logic next_in_ready;
    logic push;
    logic pop;

    assign out_valid = (count != 2'h0);
    assign out_data = slot0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_slot0 = slot0;
        next_slot1 = slot1;
        next_count = count;
        case ({push, pop})
            2'b10: begin
                if (count == 2'h0) begin
                    next_slot0 = in_data;
                end else begin
                    next_slot1 = in_data;
                end
                next_count = count + 2'h1;
            end
            2'b01: begin
                next_slot0 = slot1;
                next_count = count - 2'h1;
            end
            2'b11: begin
                if (count == 2'h1) begin
                    next_slot0 = in_data;
                end else begin
                    next_slot0 = slot1;
                    next_slot1 = in_data;
                end
            end
            default: begin
                next_count = count;
            end
        endcase
        next_in_ready = (next_count != WIT_BUF_DEPTH);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            slot0 <= 8'h00;
            slot1 <= 8'h00;
            count <= 2'h0;
            in_ready <= 1'b0;
        end else begin
            slot0 <= next_slot0;
            slot1 <= next_slot1;
            count <= next_count;
            in_ready <= next_in_ready;
        end
    end
endmodule : wit_pair_buffer

// ---- rtl/wit_link.sv ----
// Purpose: instrument end of the telemetry link to the host data computer
// Assumes: bus_clock is the link domain; system logic on clock at 25 MHz
// Notes: wave and reply bytes cross by toggle handshakes; the time word and events by toggles
module wit_link
    import wit_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic bus_clock,
    input wire logic frame_timing_pulse,
    input wire logic supervisory_data,
    output logic reply_data,
    output logic hr_high_nibble,
    output logic hr_low_nibble,
    output logic hr_bit_clock,
    output logic hr_word_sync,
    input wire logic [1:0] hr_rate,
    input wire logic wave_valid,
    output logic wave_ready,
    input wire logic [7:0] wave_byte,
    input wire logic reply_valid,
    output logic reply_ready,
    input wire logic [7:0] reply_byte,
    output logic [31:0] time_value,
    output logic time_strobe
);
    // link domain state
    logic half_phase;
    logic sup_s1;
    logic sup_s2;
    logic [1:0] rate_s1;
    logic [1:0] rate_s2;
    logic wfq_s1;
    logic wfq_s2;
    logic rpq_s1;
    logic rpq_s2;
    logic al_s1;
    logic al_s2;
    logic al_s3;
    logic sup_seen;
    logic [31:0] sup_shift;
    logic [4:0] sup_count;
    logic [31:0] time_word;
    logic time_tog;
    wit_tx_t rp_state;
    logic [7:0] rp_shift;
    logic [3:0] rp_bits;
    logic rp_ack;
    logic p_mark;
    logic n_mark;
    logic [7:0] hr_count;
    logic [1:0] hr_bit;
    logic [7:0] hr_byte;
    logic wf_ack;
    logic next_half_phase;
    logic next_sup_seen;
    logic [31:0] next_sup_shift;
    logic [4:0] next_sup_count;
    logic [31:0] next_time_word;
    logic next_time_tog;
    wit_tx_t next_rp_state;
    logic [7:0] next_rp_shift;
    logic [3:0] next_rp_bits;
    logic next_rp_ack;
    logic next_p_mark;
    logic [7:0] next_hr_count;
    logic [1:0] next_hr_bit;
    logic [7:0] next_hr_byte;
    logic next_wf_ack;
    logic next_hr_clk;
    logic next_hr_hi;
    logic next_hr_lo;
    logic next_hr_sync;
    logic hr_clk;
    logic hr_hi;
    logic hr_lo;
    logic hr_sync;
    // system domain state
    logic tt_s1;
    logic tt_s2;
    logic tt_s3;
    logic pl_s1;
    logic pl_s2;
    logic pl_s3;
    logic wak_s1;
    logic wak_s2;
    logic rak_s1;
    logic rak_s2;
    logic [31:0] time_latest;
    logic align_tog;
    logic wf_req;
    logic [7:0] wf_hold;
    logic rp_req;
    logic [7:0] rp_hold;
    logic [31:0] next_time_latest;
    logic [31:0] next_time_value;
    logic next_time_strobe;
    logic next_align_tog;
    logic next_wf_req;
    logic [7:0] next_wf_hold;
    logic next_rp_req;
    logic [7:0] next_rp_hold;
    logic next_reply_ready;
    logic buf_valid;
    logic buf_ready;
    logic [7:0] buf_data;

    wit_pair_buffer u_wave_buffer (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(wave_valid),
        .in_ready(wave_ready),
        .in_data(wave_byte),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // link synchronisers
    always_ff @(posedge bus_clock or negedge reset_n) begin
        if (!reset_n) begin
            sup_s1 <= 1'b0;
            sup_s2 <= 1'b0;
            rate_s1 <= 2'h0;
            rate_s2 <= 2'h0;
            wfq_s1 <= 1'b0;
            wfq_s2 <= 1'b0;
            rpq_s1 <= 1'b0;
            rpq_s2 <= 1'b0;
            al_s1 <= 1'b0;
            al_s2 <= 1'b0;
            al_s3 <= 1'b0;
        end else begin
            sup_s1 <= supervisory_data;
            sup_s2 <= sup_s1;
            rate_s1 <= hr_rate;
            rate_s2 <= rate_s1;
            wfq_s1 <= wf_req;
            wfq_s2 <= wfq_s1;
            rpq_s1 <= rp_req;
            rpq_s2 <= rpq_s1;
            al_s1 <= align_tog;
            al_s2 <= al_s1;
            al_s3 <= al_s2;
        end
    end

    always_comb begin
        logic [7:0] div;
        logic [3:0] hi_nib;
        logic [3:0] lo_nib;
        logic sup_bit;
        div = wit_rate_div(rate_s2);
        hi_nib = 4'h0;
        lo_nib = 4'h0;
        sup_bit = sup_seen | sup_s2;
        // halved bus clock marks each 403.2 kb/s bit
        next_half_phase = ~half_phase; // R1
        next_sup_seen = sup_bit; // R13
        next_sup_shift = sup_shift;
        next_sup_count = sup_count;
        next_time_word = time_word;
        next_time_tog = time_tog;
        if (half_phase) begin
            next_sup_seen = 1'b0;
            next_sup_shift = {sup_shift[30:0], sup_bit}; // R5
            next_sup_count = sup_count + 5'h01;
            if (sup_count == WIT_TIME_LAST) begin
                next_time_word = {sup_shift[30:0], sup_bit};
                next_time_tog = ~time_tog;
            end
        end
        if (al_s2 != al_s3) begin
            next_half_phase = 1'b0; // R4
            next_sup_seen = 1'b0;
            next_sup_count = 5'h00; // R4
        end
        // reply transmitter
        next_rp_state = rp_state;
        next_rp_shift = rp_shift;
        next_rp_bits = rp_bits;
        next_rp_ack = rp_ack;
        next_p_mark = 1'b0;
        case (rp_state)
            WIT_TX_IDLE: begin
                if (rpq_s2 != rp_ack) begin
                    next_rp_shift = rp_hold;
                    next_rp_bits = WIT_REPLY_BITS;
                    next_rp_ack = ~rp_ack;
                    next_rp_state = WIT_TX_SEND;
                end
            end
            WIT_TX_SEND: begin
                if (half_phase) begin
                    next_p_mark = rp_shift[7]; // R6
                    next_rp_shift = {rp_shift[6:0], 1'b0};
                    next_rp_bits = rp_bits - 4'h1;
                    if (rp_bits == 4'h1) begin
                        next_rp_state = WIT_TX_IDLE;
                    end
                end
            end
            default: begin
                next_rp_state = WIT_TX_IDLE;
            end
        endcase
        // high-rate output, bit period counted in bus cycles
        next_hr_count = hr_count + 8'h01; // R2
        next_hr_bit = hr_bit;
        next_hr_byte = hr_byte;
        next_wf_ack = wf_ack;
        if (hr_count >= div - 8'h01) begin
            next_hr_count = 8'h00; // R12
            if (hr_bit == WIT_NIBBLE_LAST) begin
                next_hr_bit = 2'h0;
                next_hr_byte = 8'h00;
                if (wfq_s2 != wf_ack) begin
                    next_hr_byte = wf_hold; // R9
                    next_wf_ack = ~wf_ack;
                end
            end else begin
                next_hr_bit = hr_bit + 2'h1;
            end
        end
        hi_nib = next_hr_byte[7:4];
        lo_nib = next_hr_byte[3:0];
        next_hr_hi = hi_nib[WIT_NIBBLE_LAST - next_hr_bit]; // R7
        next_hr_lo = lo_nib[WIT_NIBBLE_LAST - next_hr_bit]; // R8
        next_hr_clk = (next_hr_count >= (div >> 1)); // R10
        next_hr_sync = (next_hr_bit == 2'h0); // R11
    end

    always_ff @(posedge bus_clock or negedge reset_n) begin
        if (!reset_n) begin
            half_phase <= 1'b0;
            sup_seen <= 1'b0;
            sup_shift <= 32'h00000000;
            sup_count <= 5'h00;
            time_word <= 32'h00000000;
            time_tog <= 1'b0;
            rp_state <= WIT_TX_IDLE;
            rp_shift <= 8'h00;
            rp_bits <= 4'h0;
            rp_ack <= 1'b0;
            p_mark <= 1'b0;
            hr_count <= 8'hFF;
            hr_bit <= WIT_NIBBLE_LAST;
            hr_byte <= 8'h00;
            wf_ack <= 1'b0;
            hr_clk <= 1'b0;
            hr_hi <= 1'b0;
            hr_lo <= 1'b0;
            hr_sync <= 1'b0;
        end else begin
            half_phase <= next_half_phase;
            sup_seen <= next_sup_seen;
            sup_shift <= next_sup_shift;
            sup_count <= next_sup_count;
            time_word <= next_time_word;
            time_tog <= next_time_tog;
            rp_state <= next_rp_state;
            rp_shift <= next_rp_shift;
            rp_bits <= next_rp_bits;
            rp_ack <= next_rp_ack;
            p_mark <= next_p_mark;
            hr_count <= next_hr_count;
            hr_bit <= next_hr_bit;
            hr_byte <= next_hr_byte;
            wf_ack <= next_wf_ack;
            hr_clk <= next_hr_clk;
            hr_hi <= next_hr_hi;
            hr_lo <= next_hr_lo;
            hr_sync <= next_hr_sync;
        end
    end

    // falling edge ends the first quarter of a one
    always_ff @(negedge bus_clock or negedge reset_n) begin
        if (!reset_n) begin
            n_mark <= 1'b0;
        end else begin
            n_mark <= p_mark;
        end
    end

    assign reply_data = p_mark & ~n_mark; // R13
    assign hr_high_nibble = hr_hi;
    assign hr_low_nibble = hr_lo;
    assign hr_bit_clock = hr_clk;
    assign hr_word_sync = hr_sync;

    // system synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tt_s1 <= 1'b0;
            tt_s2 <= 1'b0;
            tt_s3 <= 1'b0;
            pl_s1 <= 1'b0;
            pl_s2 <= 1'b0;
            pl_s3 <= 1'b0;
            wak_s1 <= 1'b0;
            wak_s2 <= 1'b0;
            rak_s1 <= 1'b0;
            rak_s2 <= 1'b0;
        end else begin
            tt_s1 <= time_tog;
            tt_s2 <= tt_s1;
            tt_s3 <= tt_s2;
            pl_s1 <= frame_timing_pulse;
            pl_s2 <= pl_s1;
            pl_s3 <= pl_s2;
            wak_s1 <= wf_ack;
            wak_s2 <= wak_s1;
            rak_s1 <= rp_ack;
            rak_s2 <= rak_s1;
        end
    end

    assign buf_ready = (wf_req == wak_s2);

    always_comb begin
        next_time_latest = time_latest;
        next_time_value = time_value;
        next_time_strobe = 1'b0;
        next_align_tog = align_tog;
        if (tt_s2 != tt_s3) begin
            next_time_latest = time_word;
        end
        // rising timing pulse: publish time, realign the link
        if (pl_s2 && !pl_s3) begin
            next_time_value = time_latest; // R3
            next_time_strobe = 1'b1;
            next_align_tog = ~align_tog; // R4
        end
        next_wf_req = wf_req;
        next_wf_hold = wf_hold;
        if (buf_valid && buf_ready) begin
            next_wf_hold = buf_data;
            next_wf_req = ~wf_req;
        end
        next_rp_req = rp_req;
        next_rp_hold = rp_hold;
        if (reply_valid && reply_ready) begin
            next_rp_hold = reply_byte;
            next_rp_req = ~rp_req;
        end
        next_reply_ready = (next_rp_req == rak_s2);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            time_latest <= 32'h00000000;
            time_value <= 32'h00000000;
            time_strobe <= 1'b0;
            align_tog <= 1'b0;
            wf_req <= 1'b0;
            wf_hold <= 8'h00;
            rp_req <= 1'b0;
            rp_hold <= 8'h00;
            reply_ready <= 1'b0;
        end else begin
            time_latest <= next_time_latest;
            time_value <= next_time_value;
            time_strobe <= next_time_strobe;
            align_tog <= next_align_tog;
            wf_req <= next_wf_req;
            wf_hold <= next_wf_hold;
            rp_req <= next_rp_req;
            rp_hold <= next_rp_hold;
            reply_ready <= next_reply_ready;
        end
    end
endmodule : wit_link

// ---- testbench/wit_link_checker.sv ----
// Purpose: port checker for wit_link
// Assumes: bound to every wit_link instance
// Notes: period checks wait until hr_rate has been steady for 255 bus cycles
module wit_link_checker
    import wit_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic bus_clock,
    input wire logic frame_timing_pulse,
    input wire logic reply_data,
    input wire logic hr_high_nibble,
    input wire logic hr_low_nibble,
    input wire logic hr_bit_clock,
    input wire logic hr_word_sync,
    input wire logic [1:0] hr_rate,
    input wire logic wave_valid,
    input wire logic wave_ready,
    input wire logic reply_valid,
    input wire logic reply_ready,
    input wire logic time_strobe
);
    logic [7:0] steady;
    logic [1:0] rate_q;
    logic [2:0] rises;
    logic bclk_q;
    logic sync_q;
    logic armed;
    // counts bit clock rises per word and how long the rate has held
    always_ff @(posedge bus_clock or negedge reset_n) begin
        if (!reset_n) begin
            steady <= 8'h00;
            rate_q <= 2'h0;
            rises <= 3'h0;
            bclk_q <= 1'b0;
            sync_q <= 1'b0;
            armed <= 1'b0;
        end else begin
            rate_q <= hr_rate;
            bclk_q <= hr_bit_clock;
            sync_q <= hr_word_sync;
            if (hr_rate != rate_q) begin
                steady <= 8'h00;
            end else if (steady != 8'hFF) begin
                steady <= steady + 8'h01;
            end
            if (hr_word_sync && !sync_q) begin
                rises <= 3'h0;
                armed <= steady == 8'hFF;
            end else if (hr_bit_clock && !bclk_q && rises != 3'h7) begin
                rises <= rises + 3'h1;
            end
        end
    end
    a_strobe_one_cycle: assert property (@(posedge clock) disable iff (!reset_n)
        time_strobe |=> !time_strobe) else $error("time strobe longer than one cycle");
    a_pulse_gives_strobe: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(frame_timing_pulse) |-> ##[2:10] time_strobe) else $error("no time strobe");
    a_reply_busy: assert property (@(posedge clock) disable iff (!reset_n)
        reply_valid && reply_ready |=> !reply_ready) else $error("reply ready held");
    a_wave_refuse: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(wave_ready) |-> $past(wave_valid)) else $error("wave ready fell unprompted");
    a_reply_quarter: assert property (@(negedge bus_clock) disable iff (!reset_n)
        reply_data |=> !reply_data) else $error("reply pulse too long");
    a_word_four_bits: assert property (@(posedge bus_clock) disable iff (!reset_n)
        hr_word_sync && !sync_q && armed && steady == 8'hFF |-> rises == 3'h4)
        else $error("word sync not every four bit clocks");
    a_rate_fast: assert property (@(posedge bus_clock) disable iff (!reset_n)
        steady == 8'hFF && hr_rate == WIT_RATE_403K && $rose(hr_bit_clock)
        |-> ##2 $rose(hr_bit_clock)) else $error("fast bit period wrong");
    a_rate_slow: assert property (@(posedge bus_clock) disable iff (!reset_n)
        steady == 8'hFF && hr_rate == WIT_RATE_6K && $rose(hr_bit_clock)
        |-> ##128 ($rose(hr_bit_clock) || steady != 8'hFF)) else $error("slow bit period wrong");
    a_data_before_edge: assert property (@(posedge bus_clock) disable iff (!reset_n)
        $changed(hr_high_nibble) || $changed(hr_low_nibble) || $rose(hr_word_sync)
        |-> !hr_bit_clock) else $error("nibble changed with bit clock high");
endmodule : wit_link_checker

bind wit_link wit_link_checker u_checker (.clock(clock), .reset_n(reset_n),
    .bus_clock(bus_clock), .frame_timing_pulse(frame_timing_pulse),
    .reply_data(reply_data), .hr_high_nibble(hr_high_nibble), .hr_low_nibble(hr_low_nibble),
    .hr_bit_clock(hr_bit_clock), .hr_word_sync(hr_word_sync), .hr_rate(hr_rate),
    .wave_valid(wave_valid), .wave_ready(wave_ready), .reply_valid(reply_valid),
    .reply_ready(reply_ready), .time_strobe(time_strobe));

// ---- testbench/wit_host_model.sv ----
// Purpose: host data computer model on the far side of wit_link
// Assumes: bus_clock comes from the bench
// Notes: all-zero bytes are idle fill and are not queued
module wit_host_model
(
    input wire logic bus_clock,
    input wire logic reply_data,
    input wire logic hr_high_nibble,
    input wire logic hr_low_nibble,
    input wire logic hr_bit_clock,
    input wire logic hr_word_sync,
    output logic frame_timing_pulse,
    output logic supervisory_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] bytes_seen[$];
    int rz_marks[$];
    int bus_count = 0;
    int nib_count = 0;
    logic [3:0] hi = 4'h0;
    logic [3:0] lo = 4'h0;
    initial begin
        frame_timing_pulse = 1'b0;
        supervisory_data = 1'b0;
    end
    always @(posedge bus_clock) bus_count <= bus_count + 1;
    // reply pulses are logged by bus cycle
    always @(negedge bus_clock) begin
        if (reply_data === 1'b1) begin
            rz_marks.push_back(bus_count);
        end
    end
    // both nibble lines sampled on the bit clock rise, paired into a byte
    always @(posedge hr_bit_clock) begin
        hi = {hi[2:0], hr_high_nibble};
        lo = {lo[2:0], hr_low_nibble};
        nib_count = hr_word_sync ? 1 : nib_count + 1;
        if (nib_count == 4 && {hi, lo} != 8'h00) begin
            bytes_seen.push_back({hi, lo});
        end
    end
    task automatic frame_pulse();
        #3;
        frame_timing_pulse = 1'b1;
        #620;
        frame_timing_pulse = 1'b0;
    endtask : frame_pulse
    // one bit per two bus cycles, a one is high for a quarter bit
    task automatic send_time(input logic [31:0] word);
        for (int i = 31; i >= 0; i--) begin
            @(negedge bus_clock);
            #12;
            supervisory_data = word[i];
            #24;
            supervisory_data = 1'b0;
            @(negedge bus_clock);
        end
    endtask : send_time
endmodule : wit_host_model

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for wit_link
// Assumes: 40 ns system clock, 48 ns bus clock of unrelated phase
// Notes: host phase is free, so the time word is matched against its rotations
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic bus_clock = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] hr_rate = 2'b00;
    logic wave_valid = 1'b0;
    logic reply_valid = 1'b0;
    logic [7:0] wave_byte = 8'h00;
    logic [7:0] reply_byte = 8'h00;
    logic frame_timing_pulse, supervisory_data, reply_data, hr_high_nibble, hr_low_nibble;
    logic hr_bit_clock, hr_word_sync, wave_ready, reply_ready, time_strobe, saw_refusal;
    logic [31:0] time_value;
    int mismatches = 0;
    int n_compared = 0;
    initial begin
        forever #20 clock = ~clock;
    end
    initial begin
        #7;
        forever #24 bus_clock = ~bus_clock;
    end
    wit_link u_dut (.clock(clock), .reset_n(reset_n), .bus_clock(bus_clock),
        .frame_timing_pulse(frame_timing_pulse), .supervisory_data(supervisory_data),
        .reply_data(reply_data), .hr_high_nibble(hr_high_nibble),
        .hr_low_nibble(hr_low_nibble), .hr_bit_clock(hr_bit_clock),
        .hr_word_sync(hr_word_sync), .hr_rate(hr_rate), .wave_valid(wave_valid),
        .wave_ready(wave_ready), .wave_byte(wave_byte), .reply_valid(reply_valid),
        .reply_ready(reply_ready), .reply_byte(reply_byte), .time_value(time_value),
        .time_strobe(time_strobe));
    wit_host_model u_host (.bus_clock(bus_clock), .reply_data(reply_data),
        .hr_high_nibble(hr_high_nibble), .hr_low_nibble(hr_low_nibble),
        .hr_bit_clock(hr_bit_clock), .hr_word_sync(hr_word_sync),
        .frame_timing_pulse(frame_timing_pulse), .supervisory_data(supervisory_data));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // holds valid up; the caller lowers it after the last byte
    task automatic push(input logic to_reply, input logic [7:0] b);
        int n;
        n = 0;
        if (to_reply) begin
            reply_byte <= b;
            reply_valid <= 1'b1;
        end else begin
            wave_byte <= b;
            wave_valid <= 1'b1;
        end
        do begin
            @(posedge clock);
            n++;
            if (!to_reply && wave_ready !== 1'b1) saw_refusal = 1'b1;
        end while ((to_reply ? reply_ready : wave_ready) !== 1'b1 && n < 9000);
    endtask : push
    task automatic t_time();
        logic [31:0] word = 32'h8421_5A3C;
        logic hit;
        int n;
        u_host.frame_pulse();
        repeat (4) u_host.send_time(word);
        fork
            u_host.frame_pulse();
        join_none
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (time_strobe !== 1'b1 && n < 100);
        hit = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (time_value === ((word << i) | (word >> (32 - i)))) hit = 1'b1;
        end
        check("time strobe", time_strobe, 1'b1);
        check("time word", hit, 1'b1);
    endtask : t_time
    task automatic t_reply();
        logic [7:0] pat[2] = '{8'hA5, 8'hC3};
        int base;
        int k;
        foreach (pat[j]) begin
            u_host.rz_marks.delete();
            push(1'b1, pat[j]);
            reply_valid <= 1'b0;
            @(posedge clock);
            check("reply ready", reply_ready, 1'b0);
            repeat (60) @(posedge clock);
            k = 0;
            base = u_host.rz_marks.size() > 0 ? u_host.rz_marks[0] : 0;
            for (int i = 0; i < 8; i++) begin
                if (pat[j][7 - i]) begin
                    check("reply mark", u_host.rz_marks[k] - base, 2 * i);
                    k++;
                end
            end
            check("reply ones", u_host.rz_marks.size(), k);
        end
    endtask : t_reply
    task automatic t_wave();
        int n;
        for (int r = 0; r < 4; r++) begin
            hr_rate <= r[1:0];
            repeat (400) @(posedge clock);
            u_host.bytes_seen.delete();
            saw_refusal = 1'b0;
            for (int i = 0; i < 6; i++) push(1'b0, 8'h1E + 8'(17 * i));
            wave_valid <= 1'b0;
            n = 0;
            while (u_host.bytes_seen.size() < 6 && n < 5000) begin
                @(posedge clock);
                n++;
            end
            check("refusal", saw_refusal, 1'b1);
            check("byte count", u_host.bytes_seen.size(), 6);
            for (int i = 0; i < u_host.bytes_seen.size(); i++) begin
                check("wave byte", u_host.bytes_seen[i], 8'h1E + 8'(17 * i));
            end
        end
    endtask : t_wave
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_time();
        t_reply();
        t_wave();
        conclude();
    end
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        conclude();
    end
endmodule : tb_top
